// ===== common/esd_pkg.sv
// Constants shared by the endpoint type and slave DMA block.
// Assumes a 10-bit byte address on the CPU side and one 100 MHz clock.
package esd_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [9:0] ADDR_EP_TYPE = 10'h208;
  localparam logic [9:0] ADDR_DMA_CMD = 10'h230;
  localparam logic [9:0] ADDR_CNT_B0 = 10'h234;
  localparam logic [9:0] ADDR_CNT_B1 = 10'h235;
  localparam logic [9:0] ADDR_CNT_B2 = 10'h236;
  localparam logic [9:0] ADDR_CNT_B3 = 10'h237;

  // ----------------------------------------------------------------------
  // Endpoint type fields and reset values
  // ----------------------------------------------------------------------
  localparam int EP_CFG_W = 5;
  localparam int EP_TYPE_LSB = 0;
  localparam int EP_DBL_BIT = 2;
  localparam int EP_EN_BIT = 3;
  localparam int EP_NOZLP_BIT = 4;
  localparam logic [4:0] EP_CFG_RST = 5'h00;
  localparam logic [1:0] EP_TYPE_UNUSED = 2'h0;
  localparam logic [1:0] EP_TYPE_ISO = 2'h1;
  localparam logic [1:0] EP_TYPE_BULK = 2'h2;
  localparam logic [1:0] EP_TYPE_INTR = 2'h3;
  localparam logic [7:0] DMA_CMD_READ_VAL = 8'hff;

  // ----------------------------------------------------------------------
  // DMA commands, direction and flags
  // ----------------------------------------------------------------------
  typedef enum logic [7:0] {
    ESD_CMD_GENERIC_SLAVE_DMA_IN = 8'h00,
    ESD_CMD_GENERIC_SLAVE_DMA_OUT = 8'h01,
    ESD_CMD_RESET = 8'h11,
    ESD_CMD_STOP = 8'h13
  } esd_cmd_e;

  typedef enum logic {
    ESD_DIR_IN = 1'b0,
    ESD_DIR_OUT = 1'b1
  } esd_dir_e;

  localparam int FLAG_DONE = 0;
  localparam int FLAG_SHORT = 1;
  localparam int FLAG_STOP = 2;
  localparam int NUM_FLAGS = 3;

  localparam logic [31:0] BYTES_W16 = 32'h2;
  localparam logic [31:0] BYTES_W32 = 32'h4;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

endpackage : esd_pkg

// ===== core/esd_core.sv
// Endpoint type registers and generic slave DMA engine in counter mode.
// Assumes all pins are synchronous to clk_sys and the endpoint buffer
// side speaks valid/ready.
//
// Notes on behaviour
// - Bit 4 clear: zero-length packet follows a completed DMA IN.
// - Bit 3 enables the indexed endpoint FIFO, clear disables it.
// - Enable cleared then set resets the endpoint data toggle.
// - Bit 2 selects double buffering for the indexed endpoint.
// - Type field: 00 unused, 01 isochronous, 10 bulk, 11 interrupt.
// - Writing command 00h or 01h starts a transfer at once if idle, DMA clock enabled and endpoint enabled with a used type.
// - Shared read and write strobes go to registers or to DMA.
// - Counter bytes written low to high; count loads on top byte.
// - Counter decrements; at zero the done flag and interrupt rise.
// - Short packet, DMA reset or stop command ends a transfer.
// - Separate short-packet and counter-done interrupt reasons.
// - Configuration picks active strobes and 16 or 32 bit width.
// - Request and acknowledge polarities are chosen independently.
// - DMA data bus floats until an OUT command runs and is acknowledged; controls driven.
// - The command register is write only and reads as FFh.
// - Stop command ends transfer, flushes OUT data, sets a flag.
// - Command 11h returns the DMA core to its reset state.
`timescale 1ns/1ns
`default_nettype none

module esd_core #(
  parameter int NUM_EP = 16,
  parameter int IDX_W = $clog2(NUM_EP)
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic [esd_pkg::ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [15:0] cpu_rdata,
  input wire logic [IDX_W-1:0] ep_index,
  input wire logic dma_clock_enable,
  input wire logic byte_counter_disable,
  input wire logic dma_single_strobe,
  input wire logic dma_bus_width_32,
  input wire logic request_line_polarity,
  input wire logic acknowledge_polarity,
  input wire logic [esd_pkg::NUM_FLAGS-1:0] irq_mask,
  input wire logic [esd_pkg::NUM_FLAGS-1:0] flag_clear,
  input wire logic short_packet_end,
  input wire logic dack,
  output logic dreq,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic data_oe,
  output logic [31:0] ep_rx_data,
  output logic ep_rx_valid,
  input wire logic ep_rx_ready,
  input wire logic [31:0] ep_tx_data,
  input wire logic ep_tx_valid,
  output logic ep_tx_ready,
  output logic [NUM_EP-1:0] ep_fifo_enable,
  output logic [NUM_EP-1:0] double_buffer_enable,
  output logic [NUM_EP-1:0] suppress_zero_length_packet,
  output logic [2*NUM_EP-1:0] endpoint_transfer_type,
  output logic [3*NUM_EP-1:0] ep_kind,
  output logic [NUM_EP-1:0] ep_pid_reset,
  output logic zlp_request,
  output logic [31:0] dma_byte_count,
  output logic counter_done_flag,
  output logic short_packet_end_flag,
  output logic stop_done_flag,
  output logic dma_irq
);
  import esd_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic running;
    esd_dir_e dir;
    logic [31:0] count;
    logic [23:0] shadow;
    logic [NUM_FLAGS-1:0] flags;
    logic irq;
    logic [NUM_EP-1:0][EP_CFG_W-1:0] ep_cfg;
    logic [NUM_EP-1:0][2:0] kind;
    logic [NUM_EP-1:0] pid_reset;
    logic zlp;
    logic [1:0][31:0] bufm;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic rx_valid;
    logic tx_ready;
    logic [31:0] dout;
    logic oe;
    logic req;
    logic dreq_pin;
    logic rd_act_prev;
    logic wr_act_prev;
    logic [15:0] rdata;
  } esd_state_s;

  esd_state_s q;
  esd_state_s d;

  // One-hot iso, bulk, interrupt; an unused type decodes to no kind.
  function automatic logic [2:0] esd_decode_type(input logic [1:0] t);
    logic [2:0] k;
    k = 3'h0;
    case (t)
      EP_TYPE_ISO: k = 3'h1;
      EP_TYPE_BULK: k = 3'h2;
      EP_TYPE_INTR: k = 3'h4;
      default: k = 3'h0;
    endcase
    return k;
  endfunction : esd_decode_type

  logic pio;
  logic ack;
  logic rd_start;
  logic rd_end;
  logic wr_end;
  logic xfer;
  logic ext_push;
  logic ext_pop;
  logic ep_push;
  logic ep_pop;
  logic [31:0] step;
  logic [4:0] cur_cfg;
  logic flush;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    d.pid_reset = '0;
    d.zlp = 1'b0;
    d.rd_act_prev = ~rd_n;
    d.wr_act_prev = ~wr_n;
    pio = ~cs_n;
    ack = (dack == acknowledge_polarity);
    rd_start = ~q.rd_act_prev & ~rd_n;
    rd_end = q.rd_act_prev & rd_n;
    wr_end = q.wr_act_prev & wr_n;
    step = dma_bus_width_32 ? BYTES_W32 : BYTES_W16;
    cur_cfg = q.ep_cfg[ep_index];
    flush = 1'b0;
    // Event flags: clear first so that a set in the same cycle wins.
    d.flags = q.flags & ~flag_clear;

    // Strobes serve the register file while chip select is low.
    if (pio && wr_end) begin
      if (addr == ADDR_EP_TYPE) begin
        if (!cur_cfg[EP_EN_BIT] && wdata[EP_EN_BIT]) begin
          d.pid_reset[ep_index] = 1'b1;
        end
        d.ep_cfg[ep_index] = wdata[EP_CFG_W-1:0];
      end else if (addr == ADDR_CNT_B0) begin
        d.shadow[7:0] = wdata[7:0];
      end else if (addr == ADDR_CNT_B1) begin
        d.shadow[15:8] = wdata[7:0];
      end else if (addr == ADDR_CNT_B2) begin
        d.shadow[23:16] = wdata[7:0];
      end else if (addr == ADDR_CNT_B3) begin
        d.count = {wdata[7:0], q.shadow};
      end else if (addr == ADDR_DMA_CMD) begin
        if (wdata[7:0] == ESD_CMD_RESET) begin
          d.running = 1'b0;
          d.dir = ESD_DIR_IN;
          d.count = '0;
          d.shadow = '0;
          d.flags = '0;
          flush = 1'b1;
        end else if (wdata[7:0] == ESD_CMD_STOP) begin
          if (q.running) begin
            d.running = 1'b0;
            d.flags[FLAG_STOP] = 1'b1;
            if (q.dir == ESD_DIR_OUT) begin
              flush = 1'b1;
            end
          end
        end else if ((wdata[7:0] == ESD_CMD_GENERIC_SLAVE_DMA_IN ||
                      wdata[7:0] == ESD_CMD_GENERIC_SLAVE_DMA_OUT) && !q.running &&
                     dma_clock_enable && cur_cfg[EP_EN_BIT] &&
                     esd_decode_type(cur_cfg[1:0]) != 3'h0) begin
          d.running = 1'b1;
          d.dir = esd_dir_e'(wdata[0]);
          flush = 1'b1;
        end
      end
    end

    if (pio && rd_start) begin
      if (addr == ADDR_EP_TYPE) begin
        d.rdata = {{(16-EP_CFG_W){1'b0}}, cur_cfg};
      end else if (addr == ADDR_DMA_CMD) begin
        d.rdata = {8'h00, DMA_CMD_READ_VAL};
      end else if (addr == ADDR_CNT_B0) begin
        d.rdata = {8'h00, q.count[7:0]};
      end else if (addr == ADDR_CNT_B1) begin
        d.rdata = {8'h00, q.count[15:8]};
      end else if (addr == ADDR_CNT_B2) begin
        d.rdata = {8'h00, q.count[23:16]};
      end else if (addr == ADDR_CNT_B3) begin
        d.rdata = {8'h00, q.count[31:24]};
      end else begin
        d.rdata = 16'h0000;
      end
    end

    // ----------------------------------------------------------------------
    // External DMA side and endpoint side of the two-entry buffer
    // ----------------------------------------------------------------------
    // Outside chip select the strobes belong to the DMA when acknowledged.
    xfer = 1'b0;
    if (!pio && ack && q.running) begin
      if (q.dir == ESD_DIR_IN) begin
        xfer = (dma_single_strobe ? rd_end : wr_end) && (q.cnt != BUF_DEPTH);
      end else begin
        xfer = rd_end && (q.cnt != 2'h0);
      end
    end
    ext_push = xfer && (q.dir == ESD_DIR_IN);
    ext_pop = xfer && (q.dir == ESD_DIR_OUT);
    ep_pop = q.rx_valid && ep_rx_ready;
    ep_push = q.tx_ready && ep_tx_valid;
    if (ext_push) begin
      d.bufm[q.wp] = dma_bus_width_32 ? data_in : {16'h0000, data_in[15:0]};
    end else if (ep_push) begin
      d.bufm[q.wp] = ep_tx_data;
    end
    if (ext_push || ep_push) begin
      d.wp = ~q.wp;
    end
    if (ext_pop || ep_pop) begin
      d.rp = ~q.rp;
    end
    if ((ext_push || ep_push) && !(ext_pop || ep_pop)) begin
      d.cnt = q.cnt + 2'h1;
    end else if (!(ext_push || ep_push) && (ext_pop || ep_pop)) begin
      d.cnt = q.cnt - 2'h1;
    end
    // A command flush overrides any buffer move made in the same cycle.
    if (flush) begin
      d.cnt = '0;
      d.wp = 1'b0;
      d.rp = 1'b0;
    end

    if (xfer && !byte_counter_disable) begin
      if (q.count <= step) begin
        d.count = '0;
        d.running = 1'b0;
        d.flags[FLAG_DONE] = 1'b1;
        if (q.dir == ESD_DIR_IN && !cur_cfg[EP_NOZLP_BIT]) begin
          d.zlp = 1'b1;
        end
      end else begin
        d.count = q.count - step;
      end
    end

    if (short_packet_end && q.running && d.running) begin
      d.running = 1'b0;
      d.flags[FLAG_SHORT] = 1'b1;
    end

    // ----------------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------------
    for (int i = 0; i < NUM_EP; i++) begin
      d.kind[i] = esd_decode_type(d.ep_cfg[i][1:0]);
    end
    d.rx_valid = (d.cnt != 2'h0) && (d.dir == ESD_DIR_IN);
    d.tx_ready = d.running && (d.dir == ESD_DIR_OUT) && (d.cnt != BUF_DEPTH);
    d.dout = d.bufm[d.rp];
    d.oe = d.running && (d.dir == ESD_DIR_OUT) && ack;
    d.req = d.running &&
            ((d.dir == ESD_DIR_IN) ? (d.cnt != BUF_DEPTH) : (d.cnt != 2'h0)) &&
            (byte_counter_disable || d.count != 32'h0);
    d.dreq_pin = request_line_polarity ? d.req : ~d.req;
    d.irq = |(d.flags & irq_mask);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Output wiring
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      assign ep_fifo_enable[g] = q.ep_cfg[g][EP_EN_BIT];
      assign double_buffer_enable[g] = q.ep_cfg[g][EP_DBL_BIT];
      assign suppress_zero_length_packet[g] = q.ep_cfg[g][EP_NOZLP_BIT];
      assign endpoint_transfer_type[2*g+1:2*g] = q.ep_cfg[g][1:0];
      assign ep_kind[3*g+2:3*g] = q.kind[g];
    end
  endgenerate

  assign cpu_rdata = q.rdata;
  assign dreq = q.dreq_pin;
  assign data_out = q.dout;
  assign data_oe = q.oe;
  assign ep_rx_data = q.dout;
  assign ep_rx_valid = q.rx_valid;
  assign ep_tx_ready = q.tx_ready;
  assign ep_pid_reset = q.pid_reset;
  assign zlp_request = q.zlp;
  assign dma_byte_count = q.count;
  assign counter_done_flag = q.flags[FLAG_DONE];
  assign short_packet_end_flag = q.flags[FLAG_SHORT];
  assign stop_done_flag = q.flags[FLAG_STOP];
  assign dma_irq = q.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_cmd_reads_ff: assert property (@(posedge clk_sys) disable iff (rst)
    (pio && rd_start && addr == ADDR_DMA_CMD) |=> cpu_rdata == 16'h00ff)
    else $error("command register did not read as ff");

  a_count_load: assert property (@(posedge clk_sys) disable iff (rst)
    (pio && wr_end && addr == ADDR_CNT_B3) |=>
    dma_byte_count == {$past(wdata[7:0]), $past(q.shadow)})
    else $error("counter not loaded from top byte and shadow");

  a_low_bytes_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (pio && wr_end && addr == ADDR_CNT_B0 && !xfer) |=> $stable(dma_byte_count))
    else $error("low counter byte changed the live count");

  a_done_at_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (xfer && !byte_counter_disable && q.count <= step &&
     !(pio && wr_end && addr == ADDR_DMA_CMD)) |=>
    counter_done_flag && !q.running && dma_byte_count == 32'h0 ##1 dma_irq ||
    !$past(irq_mask[FLAG_DONE], 1))
    else $error("counter reached zero without done flag");

  a_pid_reset: assert property (@(posedge clk_sys) disable iff (rst)
    ep_pid_reset == (ep_fifo_enable & ~$past(ep_fifo_enable)))
    else $error("toggle reset does not match enable rising");

  a_type0_refused: assert property (@(posedge clk_sys) disable iff (rst)
    (pio && wr_end && addr == ADDR_DMA_CMD && !q.running &&
     cur_cfg[1:0] == EP_TYPE_UNUSED) |=> !q.running)
    else $error("transfer started on an unused endpoint");

  a_stop_ends: assert property (@(posedge clk_sys) disable iff (rst)
    (pio && wr_end && addr == ADDR_DMA_CMD && wdata[7:0] == ESD_CMD_STOP &&
     q.running) |=> !q.running && stop_done_flag)
    else $error("stop command did not end the transfer");

  a_reset_cmd: assert property (@(posedge clk_sys) disable iff (rst)
    (pio && wr_end && addr == ADDR_DMA_CMD && wdata[7:0] == ESD_CMD_RESET) |=>
    !q.running && dma_byte_count == 32'h0 && q.cnt == 2'h0 ##1 !data_oe)
    else $error("dma reset left state behind");

  a_bus_floats: assert property (@(posedge clk_sys) disable iff (rst)
    data_oe |-> $past(d.running) && q.dir == ESD_DIR_OUT)
    else $error("data bus driven without a running command");

  a_req_polarity: assert property (@(posedge clk_sys) disable iff (rst)
    dreq == ($past(request_line_polarity) ? q.req : !q.req))
    else $error("request pin polarity wrong");

  a_zlp_gate: assert property (@(posedge clk_sys) disable iff (rst)
    zlp_request |-> $past(!cur_cfg[EP_NOZLP_BIT]) && counter_done_flag)
    else $error("zero length packet despite suppression");

  a_short_end: assert property (@(posedge clk_sys) disable iff (rst)
    (short_packet_end && q.running && !(pio && wr_end)) |=>
    !q.running && (short_packet_end_flag || counter_done_flag))
    else $error("short packet did not end transfer");

endmodule : esd_core

`default_nettype wire

// ===== dv/esd_dma_model.sv
// Behavioural external DMA controller for the slave DMA port.
// Assumes dreq, dack and the strobes are sampled on clk_sys rising edges.
`timescale 1ns/1ns
`default_nettype none
module esd_dma_model (
  input wire logic clk_sys,
  input wire logic en,
  input wire logic dir_out,
  input wire logic single,
  input wire logic w32,
  input wire logic req_pol,
  input wire logic ack_pol,
  input wire logic [1:0] gap,
  input wire logic [31:0] base,
  input wire logic dreq,
  input wire logic [31:0] data_out,
  output logic dack,
  output logic rd_n,
  output logic wr_n,
  output logic [31:0] data_in,
  output logic [31:0] rd_sum,
  output logic [15:0] n_words
);
  initial begin
    {dack, rd_n, wr_n} = 3'b011;
    {data_in, rd_sum, n_words} = '0;
    forever begin
      @(posedge clk_sys);
      #1;
      dack <= en ? ack_pol : ~ack_pol;
      if (en && dreq === req_pol) begin
        data_in <= base + 32'(n_words);
        if (dir_out || single) rd_n <= 1'b0;
        else wr_n <= 1'b0;
        @(posedge clk_sys);
        #1;
        if (dir_out) rd_sum <= rd_sum ^
            (w32 ? data_out : {16'h0, data_out[15:0]});
        {rd_n, wr_n} <= 2'b11;
        @(posedge clk_sys);
        #1;
        // A released bus keeps changing so no stale word is mistaken.
        data_in <= ~data_in;
        n_words <= n_words + 16'h1;
        repeat (gap + 2) @(posedge clk_sys);
      end else begin
        data_in <= ~data_in;
      end
    end
  end
endmodule : esd_dma_model
`default_nettype wire

// ===== dv/esd_core_tb.sv
// Self-checking bench for the endpoint type and slave DMA core.
// Assumes the DMA model owns the DMA side; the bench is CPU and endpoint.
`timescale 1ns/1ns
`default_nettype none
module esd_core_tb;
  import esd_pkg::*;
  localparam logic [31:0] TXB = 32'h5a00_0000;
  logic clk_sys = 1'b0, rst = 1'b1, cs_n = 1'b1;
  logic cpu_rd_n = 1'b1, cpu_wr_n = 1'b1, m_en = 1'b0, m_dir = 1'b0;
  logic dma_clock_enable = 1'b1, dma_single_strobe = 1'b0;
  logic dma_bus_width_32 = 1'b0, short_packet_end = 1'b0, tx_on = 1'b0;
  logic request_line_polarity = 1'b1, acknowledge_polarity = 1'b1;
  logic ep_rx_ready = 1'b0, ep_tx_valid = 1'b0;
  logic [2:0] irq_mask = 3'h7, flag_clear = 3'h0;
  logic [9:0] addr = 10'h0;
  logic [15:0] wdata = 16'h0, cpu_rdata, m_words, w0;
  logic [3:0] ep_index = 4'h0;
  logic [1:0] m_gap = 2'h0;
  logic [31:0] m_base = 32'h0, seed = 32'h7a3a, tx_cnt = 32'h0, s0, c0;
  logic [31:0] ep_tx_data = TXB, data_in, data_out, ep_rx_data, m_sum;
  logic [31:0] dma_byte_count, endpoint_transfer_type;
  logic [15:0] ep_fifo_enable, double_buffer_enable, ep_pid_reset;
  logic [15:0] suppress_zero_length_packet;
  logic [47:0] ep_kind;
  logic dack, dreq, data_oe, ep_rx_valid, ep_tx_ready, zlp_request;
  logic m_rd_n, m_wr_n, dma_irq;
  logic counter_done_flag, short_packet_end_flag, stop_done_flag;
  int n_mismatch = 0, compares = 0, n_pid = 0, n_zlp = 0, cyc = 0, z0;
  logic [31:0] rxq[$];
  wire rd_n = cpu_rd_n & m_rd_n;
  wire wr_n = cpu_wr_n & m_wr_n;

  always #5 clk_sys = ~clk_sys;

  esd_core #(.NUM_EP(16)) i_esd_core (
    .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .addr(addr), .wdata(wdata),
    .rd_n(rd_n), .wr_n(wr_n), .cpu_rdata(cpu_rdata), .ep_index(ep_index),
    .dma_clock_enable(dma_clock_enable),
    .byte_counter_disable(1'b0),
    .dma_single_strobe(dma_single_strobe),
    .dma_bus_width_32(dma_bus_width_32),
    .request_line_polarity(request_line_polarity),
    .acknowledge_polarity(acknowledge_polarity), .irq_mask(irq_mask),
    .flag_clear(flag_clear), .short_packet_end(short_packet_end),
    .dack(dack), .dreq(dreq), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .ep_rx_data(ep_rx_data), .ep_rx_valid(ep_rx_valid),
    .ep_rx_ready(ep_rx_ready), .ep_tx_data(ep_tx_data),
    .ep_tx_valid(ep_tx_valid), .ep_tx_ready(ep_tx_ready),
    .ep_fifo_enable(ep_fifo_enable),
    .double_buffer_enable(double_buffer_enable),
    .suppress_zero_length_packet(suppress_zero_length_packet),
    .endpoint_transfer_type(endpoint_transfer_type), .ep_kind(ep_kind),
    .ep_pid_reset(ep_pid_reset), .zlp_request(zlp_request),
    .dma_byte_count(dma_byte_count), .counter_done_flag(counter_done_flag),
    .short_packet_end_flag(short_packet_end_flag),
    .stop_done_flag(stop_done_flag), .dma_irq(dma_irq));

  esd_dma_model i_esd_dma_model (.clk_sys(clk_sys), .en(m_en),
    .dir_out(m_dir), .single(dma_single_strobe), .w32(dma_bus_width_32),
    .req_pol(request_line_polarity), .ack_pol(acknowledge_polarity),
    .gap(m_gap), .base(m_base), .dreq(dreq), .data_out(data_out),
    .dack(dack), .rd_n(m_rd_n), .wr_n(m_wr_n), .data_in(data_in),
    .rd_sum(m_sum), .n_words(m_words));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] fit(input logic [31:0] v, input logic w);
    return w ? v : {16'h0, v[15:0]};
  endfunction : fit

  function automatic int words(input logic [31:0] nb, input logic w);
    return w ? (nb + 3) / 4 : (nb + 1) / 2;
  endfunction : words

  function automatic logic [2:0] kind(input logic [1:0] t);
    return (t == 2'h0) ? 3'h0 : 3'h1 << (t - 2'h1);
  endfunction : kind

  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    {cs_n, addr, wdata, cpu_wr_n} <= {1'b0, a, d, 1'b0};
    @(posedge clk_sys);
    cpu_wr_n <= 1'b1;
    @(posedge clk_sys);
    cs_n <= 1'b1;
    @(posedge clk_sys);
    #1;
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    {cs_n, addr, cpu_rd_n} <= {1'b0, a, 1'b0};
    repeat (2) @(posedge clk_sys);
    {cs_n, cpu_rd_n} <= 2'b11;
    #1 d = cpu_rdata;
  endtask : rd

  task automatic wait_end();
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk_sys);
      #1;
      if ((counter_done_flag | short_packet_end_flag | stop_done_flag)
          === 1'b1) break;
    end
  endtask : wait_end

  task automatic start(input logic dir, w, nz, input logic [31:0] nb);
    logic [31:0] r;
    r = rnd();
    ep_index <= r[3:0];
    wr(ADDR_EP_TYPE, {11'h0, nz, 1'b1, r[4], r[6:5] | 2'h1});
    for (int i = 0; i < 4; i++)
      wr(ADDR_CNT_B0 + 10'(i), {8'h0, nb[8*i +: 8]});
    {dma_bus_width_32, dma_single_strobe, m_dir} <= {w, r[7], dir};
    request_line_polarity <= r[8];
    acknowledge_polarity <= r[9];
    {irq_mask, m_gap, m_base} <= {r[12:10], r[14:13], rnd()};
    wr(ADDR_DMA_CMD, {15'h0, dir});
    {w0, s0, z0, c0} = {m_words, m_sum, n_zlp, tx_cnt};
    rxq.delete();
    {tx_on, m_en} <= {dir, 1'b1};
  endtask : start

  task automatic xfer(input logic dir, w, nz, input logic [31:0] nb);
    logic [31:0] xs;
    int nw;
    nw = words(nb, w);
    xs = 32'h0;
    start(dir, w, nz, nb);
    wait_end();
    {tx_on, m_en} <= 2'b00;
    repeat (12) @(posedge clk_sys);
    #1;
    check("words", 32'(m_words - w0), nw);
    check("count", dma_byte_count, 32'h0);
    check("done", counter_done_flag, 1'b1);
    check("irq", dma_irq, irq_mask[FLAG_DONE]);
    check("zlp", n_zlp - z0, !dir && !nz);
    if (!dir) check("rx n", rxq.size(), nw);
    for (int i = 0; i < nw; i++) begin
      xs ^= fit(TXB + c0 + i, w);
      if (!dir) check("rx", rxq[i], fit(m_base + w0 + i, w));
    end
    if (dir) check("out sum", m_sum ^ s0, xs);
    flag_clear <= 3'h7;
    @(posedge clk_sys);
    flag_clear <= 3'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    check("cleared", counter_done_flag, 1'b0);
  endtask : xfer

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (ep_rx_valid === 1'b1 && ep_rx_ready) rxq.push_back(ep_rx_data);
    if ((|ep_pid_reset) === 1'b1) n_pid++;
    if (zlp_request === 1'b1) n_zlp++;
    if (ep_tx_valid && ep_tx_ready === 1'b1) begin
      tx_cnt <= tx_cnt + 1;
      ep_tx_data <= TXB + tx_cnt + 1;
    end
    ep_tx_valid <= tx_on;
    ep_rx_ready <= (rnd() % 3) != 0;
    if (cyc == 60000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    logic [31:0] r;
    logic [15:0] d;
    logic [4:0] cfg;
    int n;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check("oe idle", data_oe, 1'b0);
    rd(ADDR_DMA_CMD, d);
    check("cmd rd", d[7:0], DMA_CMD_READ_VAL);
    for (int t = 0; t < 4; t++) begin
      r = rnd();
      cfg = {r[2:0], 2'(t)};
      ep_index <= r[7:4];
      wr(ADDR_EP_TYPE, {11'h0, cfg});
      rd(ADDR_EP_TYPE, d);
      check("ep cfg", d, {11'h0, cfg});
      check("fifo", ep_fifo_enable[r[7:4]], cfg[EP_EN_BIT]);
      check("dbl", double_buffer_enable[r[7:4]], cfg[EP_DBL_BIT]);
      check("nozlp", suppress_zero_length_packet[r[7:4]], cfg[4]);
      check("type", endpoint_transfer_type[2*r[7:4] +: 2], t);
      check("kind", ep_kind[3*r[7:4] +: 3], kind(2'(t)));
    end
    n = n_pid;
    wr(ADDR_EP_TYPE, 16'h0002);
    wr(ADDR_EP_TYPE, 16'h000a);
    wr(ADDR_EP_TYPE, 16'h000a);
    check("pid", n_pid - n, 1);
    r = rnd();
    for (int i = 0; i < 3; i++) wr(ADDR_CNT_B0 + 10'(i), {8'h0, r[8*i +: 8]});
    check("cnt held", dma_byte_count, 32'h0);
    wr(ADDR_CNT_B3, {8'h0, r[31:24]});
    check("cnt load", dma_byte_count, r);
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_CNT_B0 + 10'(i), d);
      check("cnt byte", d[7:0], r[8*i +: 8]);
    end
    rd(10'h3f0, d);
    check("unmapped", d, 16'h0);
    for (int i = 0; i < 2; i++) begin
      dma_clock_enable <= i[0];
      wr(ADDR_EP_TYPE, i ? 16'h0008 : 16'h000a);
      wr(ADDR_DMA_CMD, i ? 16'h0000 : 16'h0005);
      wr(ADDR_DMA_CMD, 16'h0000);
      check("refused", dreq, !request_line_polarity);
      check("cnt kept", dma_byte_count, r);
    end
    xfer(1'b0, 1'b0, 1'b0, 32'h2);
    xfer(1'b1, 1'b1, 1'b1, 32'h5);
    repeat (8) begin
      r = rnd();
      xfer(r[0], r[1], r[2], 32'(r[8:4]) + 32'h1);
    end
    start(1'b1, 1'b1, 1'b0, 32'h400);
    repeat (30) @(posedge clk_sys);
    #1;
    check("oe run", data_oe, 1'b1);
    wr(ADDR_DMA_CMD, {8'h0, ESD_CMD_STOP});
    wait_end();
    check("stop", stop_done_flag, 1'b1);
    check("not done", counter_done_flag, 1'b0);
    repeat (3) @(posedge clk_sys);
    #1;
    check("req idle", dreq, !request_line_polarity);
    {tx_on, m_en} <= 2'b00;
    wr(ADDR_DMA_CMD, {8'h0, ESD_CMD_RESET});
    check("rst flags", stop_done_flag | counter_done_flag, 1'b0);
    start(1'b1, 1'b0, 1'b0, 32'h400);
    repeat (20) @(posedge clk_sys);
    short_packet_end <= 1'b1;
    @(posedge clk_sys);
    short_packet_end <= 1'b0;
    wait_end();
    check("short", short_packet_end_flag, 1'b1);
    check("not done", counter_done_flag, 1'b0);
    conclude();
  end
endmodule : esd_core_tb
`default_nettype wire
